//--- logic/eqf_pkg.sv
// Shared constants, register map and types for the equalizer filter block
package eqf_pkg;

  // Datapath widths
  localparam int SAMPLE_W   = 12;          // Converter sample width
  localparam int CENTER_W   = 18;          // Center tap coefficient width
  localparam int SIDE_W     = 12;          // Non-center tap coefficient width
  localparam int NUM_TAPS   = 9;           // Taps per filter
  localparam int CENTER_TAP = 4;           // Index of the center tap
  localparam int HIST_D     = NUM_TAPS - 1; // Stored past samples per history
  localparam int ACC_W      = 36;          // Full precision accumulator width
  localparam int FRAC_W     = 16;          // Accumulator fraction bits (2^-16 units)
  localparam int FIFO_DEPTH = 16;          // Output buffer depth in words
  localparam int ADDR_W     = 8;           // Register address width
  localparam int DATA_W     = 32;          // Register data width

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_LINK   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_BANK_A = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_BANK_B = 8'h80;
  localparam logic [ADDR_W-1:0] BANK_SPAN  = 8'h24;  // Nine words per bank

  // Control register fields
  localparam int CTRL_MODE_LSB   = 0;      // filter_mode_select, 2 bits
  localparam int CTRL_SHARE_BIT  = 2;      // coefficient_share
  localparam int CTRL_MERGE_BIT  = 3;      // channel_merge
  localparam int CTRL_WEIGHT_LSB = 4;      // Non-center LSB weight select, 3 bits
  localparam int LINK_CFG_LSB    = 0;      // link_mode_select, 2 bits

  // Status register fields
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_FILT_LSB   = 1;      // Effective filter kind, 2 bits
  localparam int STAT_ERR_BIT    = 3;
  localparam int STAT_LEVEL_LSB  = 8;      // FIFO level, 5 bits

  // Field values and reset values
  localparam logic [1:0]          MODE_DISABLED = 2'h0;
  localparam logic [1:0]          MODE_ENABLED  = 2'h2;
  localparam logic [1:0]          MODE_RESET    = 2'h0;
  localparam logic [2:0]          WEIGHT_MAX    = 3'h6;  // Select 6 means 2^-16
  localparam logic [2:0]          WEIGHT_RESET  = 3'h0;  // Select 0 means 2^-10
  localparam logic [CENTER_W-1:0] CENTER_RESET  = 18'h10000; // Unity gain
  localparam logic [CENTER_W-1:0] SIDE_RESET    = 18'h00000;

  // Output saturation limits at the signed range of the sample width
  localparam logic signed [ACC_W-FRAC_W:0] SAT_MAX = 21'sh0007ff;
  localparam logic signed [ACC_W-FRAC_W:0] SAT_MIN = 21'sh1ff800;
  localparam logic [FRAC_W-1:0]            HALF_LSB = 16'h8000;

  // Converter channel configuration
  typedef enum logic [1:0] {
    EQF_LINK_DUAL       = 2'h0,
    EQF_LINK_SINGLE     = 2'h1,
    EQF_LINK_DUAL_INPUT = 2'h2,
    EQF_LINK_OTHER      = 2'h3
  } eqf_link_t;

  // Effective filter kind
  typedef enum logic [1:0] {
    EQF_FILT_BYPASS  = 2'h0,
    EQF_FILT_DUAL    = 2'h1,
    EQF_FILT_TIMEVAR = 2'h3,
    EQF_FILT_SINGLE  = 2'h2
  } eqf_filt_t;

  // Packed sample window and coefficient set
  typedef logic [NUM_TAPS-1:0][SAMPLE_W-1:0] eqf_win_t;
  typedef logic [NUM_TAPS-1:0][CENTER_W-1:0] eqf_coef_t;

endpackage : eqf_pkg

//--- logic/eqf_fifo.sv
// Output sample FIFO with registered read data
`timescale 1ns/1ps

module eqf_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16
) (
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  input  wire logic                       wr_valid,
  output      logic                       wr_ready,
  input  wire logic [WIDTH-1:0]           wr_data,
  output      logic                       rd_valid,
  input  wire logic                       rd_ready,
  output      logic [WIDTH-1:0]           rd_data,
  output      logic [$clog2(DEPTH):0]     level
);

  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];           // Storage words
  logic [PTR_W-1:0] wr_ptr;                // Next write slot
  logic [PTR_W-1:0] rd_ptr;                // Next read slot
  logic [PTR_W:0]   count;                 // Words in storage

  wire full     = (count == (PTR_W+1)'(DEPTH));
  wire empty    = (count == '0);
  // Output register refills whenever it is free or being drained
  wire out_load = !empty && (!rd_valid || rd_ready);
  wire push     = wr_valid && !full;

  assign wr_ready = !full;
  assign level    = count;

  // Storage write, no reset needed on data
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= wr_data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (out_load) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + (PTR_W+1)'(push) - (PTR_W+1)'(out_load);
    end
  end

  // Read data always come from a flip-flop
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_valid <= 1'b0;
      rd_data  <= '0;
    end else if (out_load) begin
      rd_valid <= 1'b1;
      rd_data  <= mem[rd_ptr];
    end else if (rd_ready) begin
      rd_valid <= 1'b0;
    end
  end

endmodule : eqf_fifo

//--- logic/eqf_equalizer_filter.sv
// Programmable nine-tap equalizer filter on the converter sample outputs
`timescale 1ns/1ps

module eqf_equalizer_filter
  import eqf_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                rst,
  input  wire logic [ADDR_W-1:0]   reg_addr,
  input  wire logic [DATA_W-1:0]   reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output      logic [DATA_W-1:0]   reg_rdata,
  input  wire logic                in_valid,
  output      logic                in_ready,
  input  wire logic [SAMPLE_W-1:0] in_a,
  input  wire logic [SAMPLE_W-1:0] in_b,
  output      logic                out_valid,
  input  wire logic                out_ready,
  output      logic [SAMPLE_W-1:0] out_a,
  output      logic [SAMPLE_W-1:0] out_b
);

  // Multiply-accumulate of one window, all in 2^-16 units, no rounding here
  function automatic logic signed [ACC_W-1:0] eqf_mac(
    input eqf_win_t  win,
    input eqf_coef_t coef,
    input logic [2:0] wsel
  );
    logic signed [ACC_W-1:0] sum;
    logic signed [ACC_W-1:0] term;
    logic [2:0]              up;
    sum  = '0;
    term = '0;
    up   = WEIGHT_MAX - wsel;
    for (int k = 0; k < NUM_TAPS; k++) begin
      if (k == CENTER_TAP) begin
        // Full 18-bit center coefficient, LSB already 2^-16
        term = ACC_W'($signed(win[k]) * $signed(coef[k]));
      end else begin
        // 12-bit side coefficient scaled up to the 2^-16 grid
        term = ACC_W'($signed(win[k]) * $signed(coef[k][SIDE_W-1:0])) <<< up;
      end
      sum = sum + term;
    end
    return sum;
  endfunction : eqf_mac

  // Convergent rounding and saturation to the sample width
  function automatic logic [SAMPLE_W-1:0] eqf_round(
    input logic signed [ACC_W-1:0] acc
  );
    logic signed [ACC_W-FRAC_W:0] q;
    logic [FRAC_W-1:0]            frac;
    logic                         bump;
    frac = acc[FRAC_W-1:0];
    // Ties go to the even code so no DC bias builds up
    bump = (frac > HALF_LSB) || ((frac == HALF_LSB) && acc[FRAC_W]);
    q    = $signed({acc[ACC_W-1], acc[ACC_W-1:FRAC_W]}) + $signed({20'h00000, bump});
    if (q > SAT_MAX) begin
      return SAT_MAX[SAMPLE_W-1:0];
    end else if (q < SAT_MIN) begin
      return SAT_MIN[SAMPLE_W-1:0];
    end
    return q[SAMPLE_W-1:0];
  endfunction : eqf_round

  // Software-visible configuration
  logic [1:0]           filter_mode_select;  // 0 off, 2 on
  logic                 coefficient_share;   // Both outputs use bank A
  logic                 channel_merge;       // Treat pair as one interleaved stream
  logic [2:0]           weight_sel;          // Side tap LSB 2^-(10+sel)
  logic [1:0]           link_mode_select;    // Converter channel configuration
  eqf_coef_t            coeff_bank_a;        // A path coefficients
  eqf_coef_t            coeff_bank_b;        // B path coefficients

  // Sample histories, index 0 newest
  logic [HIST_D-1:0][SAMPLE_W-1:0] hist_a;   // A channel, or interleaved stream
  logic [HIST_D-1:0][SAMPLE_W-1:0] hist_b;   // B channel in dual mode only

  // Pipeline stages
  logic                    s1_valid;
  logic signed [ACC_W-1:0] s1_acc_a;
  logic signed [ACC_W-1:0] s1_acc_b;
  logic                    s2_valid;
  logic [SAMPLE_W-1:0]     s2_a;
  logic [SAMPLE_W-1:0]     s2_b;

  // Buffer side
  logic                    fifo_wr_ready;
  logic [$clog2(FIFO_DEPTH):0] fifo_level;

  // Mode decode
  wire eqf_link_t link_cfg = eqf_link_t'(link_mode_select);
  wire mode_on    = (filter_mode_select == MODE_ENABLED);
  wire want_dual  = mode_on && !coefficient_share && !channel_merge;
  wire want_sgl   = mode_on && coefficient_share && channel_merge;
  wire want_tv    = mode_on && !coefficient_share && channel_merge;
  wire run_dual   = want_dual && (link_cfg == EQF_LINK_DUAL);
  wire run_sgl    = want_sgl && (link_cfg == EQF_LINK_SINGLE);
  wire run_tv     = want_tv && (link_cfg == EQF_LINK_DUAL_INPUT);
  wire filt_on    = run_dual || run_sgl || run_tv;
  // Mode 0 ignores share and merge; any other request that cannot run is an error
  wire cfg_error  = (filter_mode_select != MODE_DISABLED) && !filt_on;

  eqf_filt_t filt_kind;
  assign filt_kind = run_dual ? EQF_FILT_DUAL :
                     run_sgl  ? EQF_FILT_SINGLE :
                     run_tv   ? EQF_FILT_TIMEVAR : EQF_FILT_BYPASS;

  // Interleaved stream: in_a is the earlier sample, in_b the later one
  wire interleave = run_sgl || run_tv;

  // Windows for both outputs
  eqf_win_t win_a;
  eqf_win_t win_b;
  always_comb begin
    win_a    = '0;
    win_b    = '0;
    win_a[0] = in_a;
    win_b[0] = in_b;
    for (int k = 1; k < NUM_TAPS; k++) begin
      win_a[k] = hist_a[k-1];
      // Dual channels are independent; interleaved b sees a then history
      win_b[k] = interleave ? ((k == 1) ? in_a : hist_a[k-2]) : hist_b[k-1];
    end
  end

  // Second output uses bank B except in single channel mode
  wire eqf_coef_t coef_b_sel = run_sgl ? coeff_bank_a : coeff_bank_b;
  wire signed [ACC_W-1:0] mac_a = eqf_mac(win_a, coeff_bank_a, weight_sel);
  wire signed [ACC_W-1:0] mac_b = eqf_mac(win_b, coef_b_sel, weight_sel);
  // Bypass: place the raw sample on the 2^-16 grid so rounding returns it intact
  wire signed [ACC_W-1:0] raw_a = ACC_W'($signed(in_a)) <<< FRAC_W;
  wire signed [ACC_W-1:0] raw_b = ACC_W'($signed(in_b)) <<< FRAC_W;

  // Stall control, buffer back-pressure reaches the input
  wire adv2 = !s2_valid || fifo_wr_ready;
  wire adv1 = !s1_valid || adv2;
  wire take = in_valid && adv1;
  assign in_ready = adv1;

  // Register decode
  wire [ADDR_W-1:0] a_off  = reg_addr - OFS_BANK_A;
  wire [ADDR_W-1:0] b_off  = reg_addr - OFS_BANK_B;
  wire              a_hit  = (a_off < BANK_SPAN) && (a_off[1:0] == 2'h0);
  wire              b_hit  = (b_off < BANK_SPAN) && (b_off[1:0] == 2'h0);
  wire [3:0]        a_idx  = a_off[5:2];
  wire [3:0]        b_idx  = b_off[5:2];
  wire              ctrl_wr = reg_wr && (reg_addr == OFS_CTRL);
  wire              link_wr = reg_wr && (reg_addr == OFS_LINK);
  wire [2:0]        wsel_in = reg_wdata[CTRL_WEIGHT_LSB +: 3];
  // Selects past 2^-16 are clamped so the shared weight stays in range
  wire [2:0]        wsel_ok = (wsel_in > WEIGHT_MAX) ? WEIGHT_MAX : wsel_in;

  // Control and link configuration registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      filter_mode_select <= MODE_RESET;
      coefficient_share  <= 1'b0;
      channel_merge      <= 1'b0;
      weight_sel         <= WEIGHT_RESET;
      link_mode_select   <= EQF_LINK_DUAL;
    end else begin
      if (ctrl_wr) begin
        filter_mode_select <= reg_wdata[CTRL_MODE_LSB +: 2];
        coefficient_share  <= reg_wdata[CTRL_SHARE_BIT];
        channel_merge      <= reg_wdata[CTRL_MERGE_BIT];
        weight_sel         <= wsel_ok;
      end
      if (link_wr) begin
        link_mode_select <= reg_wdata[LINK_CFG_LSB +: 2];
      end
    end
  end

  // Coefficient banks, reset to a unity pass filter
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int k = 0; k < NUM_TAPS; k++) begin
        coeff_bank_a[k] <= (k == CENTER_TAP) ? CENTER_RESET : SIDE_RESET;
        coeff_bank_b[k] <= (k == CENTER_TAP) ? CENTER_RESET : SIDE_RESET;
      end
    end else if (reg_wr) begin
      for (int k = 0; k < NUM_TAPS; k++) begin
        // Each coefficient has its own word
        if (a_hit && (a_idx == 4'(k))) begin
          coeff_bank_a[k] <= reg_wdata[CENTER_W-1:0];
        end
        if (b_hit && (b_idx == 4'(k))) begin
          coeff_bank_b[k] <= reg_wdata[CENTER_W-1:0];
        end
      end
    end
  end

  // Read data for the addressed register
  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    if (reg_addr == OFS_CTRL) begin
      rd_mux[CTRL_MODE_LSB +: 2]   = filter_mode_select;
      rd_mux[CTRL_SHARE_BIT]       = coefficient_share;
      rd_mux[CTRL_MERGE_BIT]       = channel_merge;
      rd_mux[CTRL_WEIGHT_LSB +: 3] = weight_sel;
    end else if (reg_addr == OFS_LINK) begin
      rd_mux[LINK_CFG_LSB +: 2] = link_mode_select;
    end else if (reg_addr == OFS_STATUS) begin
      rd_mux[STAT_ACTIVE_BIT]      = filt_on;
      rd_mux[STAT_FILT_LSB +: 2]   = filt_kind;
      rd_mux[STAT_ERR_BIT]         = cfg_error;
      rd_mux[STAT_LEVEL_LSB +: 5]  = fifo_level;
    end else if (a_hit) begin
      rd_mux[CENTER_W-1:0] = coeff_bank_a[a_idx];
    end else if (b_hit) begin
      rd_mux[CENTER_W-1:0] = coeff_bank_b[b_idx];
    end
  end

  // Read data stand only in the cycle after the strobe, unmapped reads zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : '0;
    end
  end

  // Histories advance only on accepted samples
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hist_a <= '0;
      hist_b <= '0;
    end else if (take) begin
      if (interleave) begin
        // Two samples per cycle enter one stream, later sample on top
        hist_a <= {hist_a[HIST_D-3:0], in_a, in_b};
      end else begin
        hist_a <= {hist_a[HIST_D-2:0], in_a};
        hist_b <= {hist_b[HIST_D-2:0], in_b};
      end
    end
  end

  // Stage 1: full precision sums, or the raw sample in bypass
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s1_valid <= 1'b0;
      s1_acc_a <= '0;
      s1_acc_b <= '0;
    end else if (adv1) begin
      s1_valid <= in_valid;
      if (in_valid) begin
        s1_acc_a <= filt_on ? mac_a : raw_a;
        s1_acc_b <= filt_on ? mac_b : raw_b;
      end
    end
  end

  // Stage 2: the only rounding and saturation point
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s2_valid <= 1'b0;
      s2_a     <= '0;
      s2_b     <= '0;
    end else if (adv2) begin
      s2_valid <= s1_valid;
      if (s1_valid) begin
        s2_a <= eqf_round(s1_acc_a);
        s2_b <= eqf_round(s1_acc_b);
      end
    end
  end

  // Output buffer toward the downstream path
  eqf_fifo #(
    .WIDTH (2 * SAMPLE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_out_fifo (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .wr_valid (s2_valid),
    .wr_ready (fifo_wr_ready),
    .wr_data  ({s2_b, s2_a}),
    .rd_valid (out_valid),
    .rd_ready (out_ready),
    .rd_data  ({out_b, out_a}),
    .level    (fifo_level)
  );

endmodule : eqf_equalizer_filter

//--- dv/eqf_filter_chk.sv
// Port-level assertions and covers for the equalizer filter top
`timescale 1ns/1ps

module eqf_filter_chk
  import eqf_pkg::*;
(
  input wire logic                sys_clk,
  input wire logic                rst,
  input wire logic [ADDR_W-1:0]   reg_addr,
  input wire logic [DATA_W-1:0]   reg_wdata,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [DATA_W-1:0]   reg_rdata,
  input wire logic                in_valid,
  input wire logic                in_ready,
  input wire logic [SAMPLE_W-1:0] in_a,
  input wire logic [SAMPLE_W-1:0] in_b,
  input wire logic                out_valid,
  input wire logic                out_ready,
  input wire logic [SAMPLE_W-1:0] out_a,
  input wire logic [SAMPLE_W-1:0] out_b
);
  // One domain, so one clock and one reset serve every property
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Read data only stands in the slot after a read strobe
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data not zero outside a read slot");
  // Unmapped places read as zero
  unmapped_zero_a: assert property ($past(reg_rd) && $past(reg_addr) == 8'hfc |-> reg_rdata == '0)
    else $error("unmapped read not zero");
  // Link field is two bits wide
  link_width_a: assert property ($past(reg_rd) && $past(reg_addr) == OFS_LINK |-> reg_rdata[31:2] == '0)
    else $error("link readback has stray bits");
  // Weight select never exceeds the finest step
  ctrl_fields_a: assert property ($past(reg_rd) && $past(reg_addr) == OFS_CTRL
    |-> reg_rdata[6:4] <= WEIGHT_MAX && reg_rdata[31:7] == '0) else $error("control field out of range");
  // Active flag agrees with the reported filter kind
  status_kind_a: assert property ($past(reg_rd) && $past(reg_addr) == OFS_STATUS
    |-> reg_rdata[0] == (reg_rdata[2:1] != 2'h0)) else $error("status active and kind disagree");
  // A stalled pair holds still until taken
  out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_a) && $stable(out_b))
    else $error("output pair changed while stalled");
  // An empty pipeline answers three edges after the take, first seen at the fourth sample
  first_latency_a: assert property ($rose(out_valid) |-> $past(in_valid && in_ready, 4))
    else $error("first output not three cycles after input");
  // Nothing buffered means room for input
  ready_empty_a: assert property (!out_valid |-> in_ready)
    else $error("input refused with empty pipeline");

  // Main scenarios reached
  stall_c: cover property (out_valid && !out_ready);
  refuse_c: cover property (in_valid && !in_ready);
  cfg_err_c: cover property ($past(reg_rd) && $past(reg_addr) == OFS_STATUS && reg_rdata[3]);
endmodule : eqf_filter_chk

bind eqf_equalizer_filter eqf_filter_chk eqf_filter_chk_inst (
  .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_valid(in_valid), .in_ready(in_ready),
  .in_a(in_a), .in_b(in_b), .out_valid(out_valid), .out_ready(out_ready),
  .out_a(out_a), .out_b(out_b)
);

//--- dv/eqf_tb_partner.sv
// Downstream sink model: takes pairs promptly, with random gaps, or not at all
`timescale 1ns/1ps

module eqf_tb_partner (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic [1:0] stall,
  output      logic       out_ready
);
  // Ready moves only just after an edge, as a synchronous sink would
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      out_ready <= 1'b0;
    end else begin
      case (stall)
        2'h0: out_ready <= 1'b1;           // Prompt
        2'h1: out_ready <= 1'($urandom);   // Slow, random gaps
        default: out_ready <= 1'b0;        // Backs the buffer up
      endcase
    end
  end
endmodule : eqf_tb_partner

//--- dv/testbench.sv
// Self-checking bench for the equalizer filter with a reference filter model
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end

module testbench import eqf_pkg::*;;
  typedef struct { logic [23:0] v; logic chk; } eqf_exp_t;
  typedef struct { logic [31:0] v; logic [31:0] m; } eqf_rexp_t;
  logic              sys_clk, rst, reg_wr, reg_rd, in_valid, in_ready, out_valid, out_ready;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0]       reg_wdata, reg_rdata;
  logic [11:0]       in_a, in_b, out_a, out_b;
  logic [1:0]        stall, kind;
  logic              rd_q, ok;
  int                n_fail = 0, n_compared = 0, sel, n, i, k;
  int                ha[9], hb[9], hs[9];         // Bench sample histories
  logic [17:0]       ca[9], cb[9];                // Coefficients as written
  eqf_exp_t          sq[$], s;                    // Expected output pairs
  eqf_rexp_t         rq[$], r;                    // Expected read data
  // Config table: control nibble, link mode, expected status low nibble
  logic [3:0] t_ctrl[9] = '{4'h0, 4'h2, 4'he, 4'ha, 4'h2, 4'he, 4'ha, 4'h6, 4'h1};
  logic [1:0] t_link[9] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h1, 2'h0, 2'h1, 2'h3, 2'h0};
  logic [3:0] t_stat[9] = '{4'h0, 4'h3, 4'h5, 4'h7, 4'h8, 4'h8, 4'h8, 4'h8, 4'h8};

  eqf_equalizer_filter eqf_equalizer_filter_inst (.sys_clk(sys_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .in_valid(in_valid), .in_ready(in_ready), .in_a(in_a),
    .in_b(in_b), .out_valid(out_valid), .out_ready(out_ready), .out_a(out_a), .out_b(out_b));
  eqf_tb_partner eqf_tb_partner_inst (.sys_clk(sys_clk), .rst(rst), .stall(stall),
    .out_ready(out_ready));

  // 125 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Full precision sum, rounded to even and saturated only at the end
  function automatic logic [11:0] fir(input int h[9], input logic [17:0] c[9]);
    longint acc = 0;
    longint q;
    for (int j = 0; j < 9; j++) begin
      if (j == CENTER_TAP) acc += longint'($signed(c[j])) * h[j];
      else acc += (longint'($signed(c[j][11:0])) <<< (6 - sel)) * h[j];
    end
    q = acc >>> 16;
    if (acc[15:0] > 16'h8000 || (acc[15:0] == 16'h8000 && q[0])) q++;
    if (q > 2047) q = 2047;
    if (q < -2048) q = -2048;
    return q[11:0];
  endfunction : fir

  task automatic shift(inout int h[9], input int x);
    for (int j = 8; j > 0; j--) h[j] = h[j-1];
    h[0] = x;
  endtask : shift

  task automatic end_sim();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read; the monitor compares the masked data in the slot after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    rq.push_back('{e, m});
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask : rd

  // Offer one pair, held until an edge sees it taken or lim edges pass; expectation from the model
  task automatic push(input logic chk, input int lim, output logic tk);
    logic [11:0] xa, xb, ea, eb;
    xa = 12'($urandom);
    xb = 12'($urandom);
    ea = xa;
    eb = xb;
    shift(ha, int'($signed(xa)));
    shift(hb, int'($signed(xb)));
    if (kind == EQF_FILT_DUAL) ea = fir(ha, ca);
    if (kind == EQF_FILT_DUAL) eb = fir(hb, cb);
    shift(hs, int'($signed(xa)));
    if (kind[1]) ea = fir(hs, ca);
    shift(hs, int'($signed(xb)));
    if (kind == EQF_FILT_SINGLE) eb = fir(hs, ca);
    if (kind == EQF_FILT_TIMEVAR) eb = fir(hs, cb);
    in_valid <= 1'b1;
    in_a <= xa;
    in_b <= xb;
    tk = 1'b0;
    for (int j = 0; j < lim && !tk; j++) begin
      @(negedge sys_clk);
      tk = in_ready;
      @(posedge sys_clk);
    end
    if (tk) sq.push_back('{{ea, eb}, chk});
  endtask : push

  task automatic send(input logic chk);
    push(chk, 200, ok);
    if (!ok) begin
      n_fail++;
      end_sim();
    end
  endtask : send

  // Release the input; released lines show the inverse of the last value
  task automatic idle();
    in_valid <= 1'b0;
    in_a <= ~in_a;
    in_b <= ~in_b;
    @(posedge sys_clk);
  endtask : idle

  task automatic drain();
    for (int j = 0; j < 3000 && sq.size() > 0; j++) @(posedge sys_clk);
    if (sq.size() > 0) begin
      n_fail++;
      end_sim();
    end
  endtask : drain

  // Register read monitor
  always @(posedge sys_clk) begin
    if (rd_q && rq.size() > 0) begin
      r = rq.pop_front();
      `CHK("reg_rdata", r.v & r.m, reg_rdata & r.m)
    end
    rd_q = reg_rd;
  end

  // Output monitor: every taken pair is matched to the oldest note
  always @(posedge sys_clk) begin
    if (!rst && out_valid && out_ready) begin
      if (sq.size() == 0) `CHK("extra_output", 1'b0, 1'b1)
      else begin
        s = sq.pop_front();
        if (s.chk) `CHK("out_a", s.v[23:12], out_a)
        if (s.chk) `CHK("out_b", s.v[11:0], out_b)
      end
    end
  end

  initial begin
    {rst, reg_wr, reg_rd, in_valid, rd_q} = 5'h10;
    {reg_addr, reg_wdata, in_a, in_b, stall, kind} = '0;
    void'($urandom(35721));
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    // Reset values, clamp of the weight select, unmapped place
    rd(OFS_CTRL, 32'h0, '1);
    rd(OFS_LINK, 32'h0, '1);
    rd(OFS_BANK_A + 8'h10, 32'h10000, '1);
    rd(OFS_BANK_B, 32'h0, '1);
    wr(8'hfc, '1);
    rd(8'hfc, 32'h0, '1);
    wr(OFS_CTRL, 32'h70);
    rd(OFS_CTRL, 32'h60, 32'h70);
    $display("test registers done");
    // Nine mode and link pairings, with random banks and weight
    for (i = 0; i < 9; i++) begin
      sel = $urandom_range(6);
      for (k = 0; k < 9; k++) begin
        ca[k] = (k == CENTER_TAP) ? 18'($urandom) : {6'h0, 12'($urandom)};
        cb[k] = (k == CENTER_TAP) ? 18'($urandom) : {6'h0, 12'($urandom)};
        wr(OFS_BANK_A + 8'(4 * k), {14'h0, ca[k]});
        wr(OFS_BANK_B + 8'(4 * k), {14'h0, cb[k]});
      end
      k = $urandom_range(8);
      rd(OFS_BANK_B + 8'(4 * k), {14'h0, cb[k]}, '1);
      wr(OFS_LINK, {30'h0, t_link[i]});
      wr(OFS_CTRL, {25'h0, 3'(sel), t_ctrl[i]});
      rd(OFS_STATUS, {28'h0, t_stat[i]}, 32'hf);
      kind = t_stat[i][2:1];
      stall <= 2'h1;
      for (k = 0; k < 36; k++) send(k >= 12);
      idle();
      drain();
      stall <= 2'h0;
      $display("test config %0d done", i);
    end
    // Buffer fills until refused, then drains while the sink is slow
    wr(OFS_CTRL, 32'h0);
    kind = 2'h0;
    stall <= 2'h2;
    n = 0;
    do begin
      push(1'b1, 4, ok);
      n += int'(ok);
    end while (ok && n < 40);
    `CHK("fill_count", 19, n)
    idle();
    stall <= 2'h1;
    drain();
    repeat (3) @(posedge sys_clk);
    $display("test buffer done");
    end_sim();
  end
endmodule : testbench
